// *** src/scid_regs.svh ***
/*
 Register map and constants for the servo command input decoder.
 Assumes inclusion by scid_pkg and by design modules; definitions only.
*/
`ifndef SCID_REGS_SVH
`define SCID_REGS_SVH

`define SCID_ADDR_W 4
`define SCID_DATA_W 32
`define SCID_REG_CFG 4'h0
`define SCID_REG_TLIM 4'h1
`define SCID_REG_STAT 4'h2
`define SCID_REG_PCNT 4'h3
`define SCID_REG_GAIN 4'h4

`define SCID_CFG_PORT 0
`define SCID_CFG_FMT_LO 1
`define SCID_CFG_FMT_HI 2
`define SCID_CFG_CLMP_LO 3
`define SCID_CFG_CLMP_HI 4
`define SCID_CFG_VFS 5
`define SCID_CFG_GMODE 6
`define SCID_CFG_TLS_LO 7
`define SCID_CFG_TLS_HI 8
`define SCID_CFG_TSL 9
`define SCID_CFG_RESET 32'h0000_0000
`define SCID_TLIM_RESET 32'h0000_0000
`define SCID_GAIN_RESET 32'h0000_0000

`define SCID_FMT_CNT 2'h0
`define SCID_FMT_STEP 2'h1
`define SCID_FMT_QUAD 2'h2
`define SCID_CLMP_OFF 2'h0
`define SCID_CLMP_ZERO 2'h1
`define SCID_CLMP_DIR 2'h2
`define SCID_TLS_SWITCH 2'h3

`define SCID_CLK_HZ 20000000
`define SCID_LD_MAX_PPS 500000
`define SCID_OC_MAX_PPS 200000
`define SCID_LD_MIN_CYC (`SCID_CLK_HZ / `SCID_LD_MAX_PPS)
`define SCID_OC_MIN_CYC (`SCID_CLK_HZ / `SCID_OC_MAX_PPS)
`define SCID_ZERO_W 32'h0000_0000
`define SCID_ENC_FRAMES 4'h8
`define SCID_ENC_TURN_BIT 1
`define SCID_ENC_INCR_BIT 2
`define SCID_TLIM_FIRST_HI 15
`define SCID_TLIM_SECOND_HI 31
`define SCID_TLIM_SECOND_LO 16

`endif

// *** src/scid_pkg.sv ***
/*
 Types for the servo command input decoder.
 Assumes scid_regs.svh is on the include path.
*/
`include "scid_regs.svh"
package scid_pkg;
	typedef enum logic [2:0] {
		SCID_ENC_IDLE = 3'b001,
		SCID_ENC_TURN = 3'b010,
		SCID_ENC_INCR = 3'b100
	} scid_enc_t;
endpackage

// *** src/scid_sync.sv ***
/*
 Three-flop synchroniser with agreement filter for external pins.
 Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module scid_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} scid_sync_t;
	scid_sync_t st_ff, nxt_st;
	always_comb begin
		nxt_st = st_ff;
		if (ce) begin
			nxt_st.s1 = pin_in;
			nxt_st.s2 = st_ff.s1;
			nxt_st.s3 = st_ff.s2;
			for (int i = 0; i < W; i++) begin
				// Level moves only when second and third stages agree
				if (st_ff.s2[i] == st_ff.s3[i])
					nxt_st.lvl[i] = st_ff.s3[i];
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign level = st_ff.lvl;
endmodule

// *** src/scid_decoder.sv ***
/*
 Servo command input decoder: pulse port/format selection, travel permits,
 zero-speed clamp, direction switch, filter/gain/torque-limit switches,
 encoder data request sequencing, register port.
 Assumes pins are asynchronous; register master is on clk_sys.
*/
// Implementation choices: the address-and-strobe port and the register offsets.
//
// Behaviour
// [RULE_01] Port select 0 takes open-collector pulses, otherwise line-driver pulses.
// [RULE_02] Line-driver pulses up to 500 kpps are accepted.
// [RULE_03] Open-collector pulses up to 200 kpps are accepted.
// [RULE_04] Format selects count pulses, step plus direction, or quadrature.
// [RULE_05] Reverse motion prohibited while reverse permit is off.
// [RULE_06] Forward motion prohibited while forward permit is off.
// [RULE_07] Clamp select 1: clamp input off forces speed command zero.
// [RULE_08] Clamp select 2: direction switch off forward, on reverse.
// [RULE_09] Filter select 1: switch chooses filter set one or two.
// [RULE_10] Torque select 0-2, gain mode 0: switch chooses PI or P.
// [RULE_11] Gain mode 1: switch chooses gain set one or two.
// [RULE_12] Torque select 3: switch chooses first or second torque limit.
// [RULE_13] Encoder request rising sends multi-turn count then incremental pulses.
// [RULE_14] Torque mode: analog input is torque command or speed limit.
// [RULE_15] All pin inputs are synchronised before decoding; torque_mode bypasses the synchroniser.
`timescale 1ns/1ps
`include "scid_regs.svh"
module scid_decoder #(
	parameter int CNT_W = 32,
	parameter int SPD_W = 16
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [`SCID_ADDR_W-1:0] reg_addr,
	input wire logic [`SCID_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`SCID_DATA_W-1:0] reg_rdata,
	input wire logic oc_pulse_a_in,
	input wire logic oc_pulse_b_in,
	input wire logic ld_pulse_a_in,
	input wire logic ld_pulse_b_in,
	input wire logic reverse_travel_permit,
	input wire logic forward_travel_permit,
	input wire logic zero_speed_clamp_in,
	input wire logic speed_direction_switch_in,
	input wire logic vibration_filter_switch_in,
	input wire logic gain_switch_in,
	input wire logic torque_limit_switch_in,
	input wire logic encoder_data_request,
	input wire logic torque_mode,
	input wire logic [SPD_W-1:0] speed_cmd_in,
	input wire logic [SPD_W-1:0] shared_analog_in,
	output logic pos_step,
	output logic pos_dir,
	output logic [SPD_W-1:0] speed_cmd_out,
	output logic speed_cmd_reverse,
	output logic forward_allowed,
	output logic reverse_allowed,
	output logic filter_set_two,
	output logic p_only_control,
	output logic gain_set_two,
	output logic [15:0] torque_limit_active,
	output logic [SPD_W-1:0] torque_cmd_analog_a,
	output logic [SPD_W-1:0] speed_limit_analog,
	output logic enc_send_multiturn,
	output logic enc_send_incremental
);
	import scid_pkg::*;

	localparam int NSYNC = 12;

	typedef struct packed {
		logic [`SCID_DATA_W-1:0] cfg;
		logic [`SCID_DATA_W-1:0] tlim;
		logic [`SCID_DATA_W-1:0] gain;
		logic [`SCID_DATA_W-1:0] rdata;
		logic [CNT_W-1:0] pcnt;
		logic a_prev;
		logic b_prev;
		logic req_prev;
		scid_enc_t enc;
		logic [3:0] enc_cnt;
		logic step;
		logic dir;
		logic [SPD_W-1:0] spd;
		logic spd_rev;
		logic fwd_ok;
		logic rev_ok;
		logic filt2;
		logic ponly;
		logic gain2;
		logic [15:0] tl;
		logic [SPD_W-1:0] tcmd;
		logic [SPD_W-1:0] spd_lim;
		logic limit_hit;
	} scid_state_t;

	scid_state_t st_ff, nxt_st;
	logic [NSYNC-1:0] sync_raw, sync_lvl;
	logic sa_oc;
	logic sb_oc;
	logic sa_ld;
	logic sb_ld;
	logic s_rev;
	logic s_fwd;
	logic s_clamp;
	logic s_dirsw;
	logic s_filt;
	logic s_gainsw;
	logic s_tls;
	logic s_req;

	assign sync_raw = {
		oc_pulse_a_in,
		oc_pulse_b_in,
		ld_pulse_a_in,
		ld_pulse_b_in,
		reverse_travel_permit,
		forward_travel_permit,
		zero_speed_clamp_in,
		speed_direction_switch_in,
		vibration_filter_switch_in,
		gain_switch_in,
		torque_limit_switch_in,
		encoder_data_request
	};

	scid_sync #(.W(NSYNC)) u_sync ( // RULE_15
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.pin_in(sync_raw),
		.level(sync_lvl)
	);

	assign {
		sa_oc,
		sb_oc,
		sa_ld,
		sb_ld,
		s_rev,
		s_fwd,
		s_clamp,
		s_dirsw,
		s_filt,
		s_gainsw,
		s_tls,
		s_req
	} = sync_lvl;

	// Two-bit field extract, used for every multi-bit config field
	function automatic logic [1:0] fld2(input logic [`SCID_DATA_W-1:0] r, input int lo);
		fld2 = r[lo +: 2];
	endfunction

	// True when the travel inputs permit motion in the given direction
	function automatic logic dir_ok(input logic fwd_dir, input logic fwd_en, input logic rev_en);
		dir_ok = fwd_dir ? fwd_en : rev_en;
	endfunction

	logic a_sel, b_sel, step_ev, dir_ev;
	logic [1:0] fmt, clmp, tls;

	always_comb begin
		fmt = fld2(st_ff.cfg, `SCID_CFG_FMT_LO);
		clmp = fld2(st_ff.cfg, `SCID_CFG_CLMP_LO);
		tls = fld2(st_ff.cfg, `SCID_CFG_TLS_LO);
		// Port choice
		if (st_ff.cfg[`SCID_CFG_PORT] == 1'b0) begin // RULE_01 RULE_03
			a_sel = sa_oc;
			b_sel = sb_oc;
		end else begin // RULE_02
			a_sel = sa_ld;
			b_sel = sb_ld;
		end
		step_ev = 1'b0;
		dir_ev = 1'b0;
		case (fmt) // RULE_04
			`SCID_FMT_CNT: begin
				// A counts reverse, B counts forward
				if (a_sel && !st_ff.a_prev) begin
					step_ev = 1'b1;
					dir_ev = 1'b0;
				end else if (b_sel && !st_ff.b_prev) begin
					step_ev = 1'b1;
					dir_ev = 1'b1;
				end
			end
			`SCID_FMT_STEP: begin
				step_ev = a_sel && !st_ff.a_prev;
				dir_ev = b_sel;
			end
			`SCID_FMT_QUAD: begin
				// Count one edge per cycle, A before B; direction from phase relation
				if (a_sel != st_ff.a_prev) begin
					step_ev = 1'b1;
					dir_ev = a_sel ^ b_sel;
				end else if (b_sel != st_ff.b_prev) begin
					step_ev = 1'b1;
					dir_ev = ~(a_sel ^ b_sel);
				end
			end
			default: begin
				step_ev = 1'b0;
				dir_ev = 1'b0;
			end
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		if (ce) begin
			nxt_st.a_prev = a_sel;
			nxt_st.b_prev = b_sel;
			nxt_st.fwd_ok = s_fwd; // RULE_06
			nxt_st.rev_ok = s_rev; // RULE_05
			// Steps into a prohibited direction are dropped and flagged
			nxt_st.step = 1'b0;
			if (step_ev) begin
				if (dir_ok(dir_ev, s_fwd, s_rev)) begin // RULE_05 RULE_06
					nxt_st.step = 1'b1;
					nxt_st.dir = dir_ev;
					nxt_st.pcnt = dir_ev ? st_ff.pcnt + CNT_W'(1) : st_ff.pcnt - CNT_W'(1);
				end else begin
					nxt_st.limit_hit = 1'b1;
				end
			end
			// Speed command path
			nxt_st.spd = speed_cmd_in;
			nxt_st.spd_rev = 1'b0;
			case (clmp)
				`SCID_CLMP_ZERO: begin
					if (!s_clamp)
						nxt_st.spd = SPD_W'(`SCID_ZERO_W); // RULE_07
				end
				`SCID_CLMP_DIR: begin
					nxt_st.spd_rev = s_dirsw; // RULE_08
				end
				default: begin
					nxt_st.spd = speed_cmd_in;
				end
			endcase
			if (!dir_ok(!nxt_st.spd_rev, s_fwd, s_rev))
				nxt_st.spd = SPD_W'(`SCID_ZERO_W); // RULE_05 RULE_06
			nxt_st.filt2 = st_ff.cfg[`SCID_CFG_VFS] ? s_filt : 1'b0; // RULE_09
			nxt_st.ponly = 1'b0;
			nxt_st.gain2 = 1'b0;
			if (st_ff.cfg[`SCID_CFG_GMODE])
				nxt_st.gain2 = s_gainsw; // RULE_11
			else if (tls != `SCID_TLS_SWITCH)
				nxt_st.ponly = s_gainsw; // RULE_10
			if (tls == `SCID_TLS_SWITCH && s_tls)
				nxt_st.tl = st_ff.tlim[`SCID_TLIM_SECOND_HI:`SCID_TLIM_SECOND_LO]; // RULE_12
			else
				nxt_st.tl = st_ff.tlim[`SCID_TLIM_FIRST_HI:0];
			nxt_st.tcmd = SPD_W'(`SCID_ZERO_W);
			nxt_st.spd_lim = SPD_W'(`SCID_ZERO_W);
			if (torque_mode) begin
				if (st_ff.cfg[`SCID_CFG_TSL])
					nxt_st.spd_lim = shared_analog_in; // RULE_14
				else
					nxt_st.tcmd = shared_analog_in; // RULE_14
			end
			// Encoder data sequence on request rising
			nxt_st.req_prev = s_req;
			case (st_ff.enc)
				SCID_ENC_IDLE: begin
					if (s_req && !st_ff.req_prev) begin // RULE_13
						nxt_st.enc = SCID_ENC_TURN;
						nxt_st.enc_cnt = `SCID_ENC_FRAMES;
					end
				end
				SCID_ENC_TURN: begin
					nxt_st.enc_cnt = st_ff.enc_cnt - 4'h1;
					if (st_ff.enc_cnt == 4'h1) begin // RULE_13
						nxt_st.enc = SCID_ENC_INCR;
						nxt_st.enc_cnt = `SCID_ENC_FRAMES;
					end
				end
				SCID_ENC_INCR: begin
					nxt_st.enc_cnt = st_ff.enc_cnt - 4'h1;
					if (st_ff.enc_cnt == 4'h1)
						nxt_st.enc = SCID_ENC_IDLE;
				end
				default: begin
					nxt_st.enc = SCID_ENC_IDLE;
				end
			endcase
			if (!s_req)
				nxt_st.enc = SCID_ENC_IDLE;
			// Register port
			nxt_st.rdata = '0;
			if (reg_wr) begin
				case (reg_addr)
					`SCID_REG_CFG: nxt_st.cfg = reg_wdata;
					`SCID_REG_TLIM: nxt_st.tlim = reg_wdata;
					`SCID_REG_GAIN: nxt_st.gain = reg_wdata;
					`SCID_REG_STAT: begin
						// Writing 1 clears the limit flag; a new hit wins
						if (reg_wdata[0] && !(step_ev && !dir_ok(dir_ev, s_fwd, s_rev)))
							nxt_st.limit_hit = 1'b0;
					end
					default: nxt_st.cfg = st_ff.cfg;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
					`SCID_REG_CFG: nxt_st.rdata = st_ff.cfg;
					`SCID_REG_TLIM: nxt_st.rdata = st_ff.tlim;
					`SCID_REG_GAIN: nxt_st.rdata = st_ff.gain;
					`SCID_REG_STAT: nxt_st.rdata = {24'h000000, st_ff.enc == SCID_ENC_IDLE ? 1'b0 : 1'b1,
						st_ff.gain2, st_ff.ponly, st_ff.filt2, st_ff.dir, st_ff.rev_ok, st_ff.fwd_ok,
						st_ff.limit_hit};
					`SCID_REG_PCNT: nxt_st.rdata = `SCID_DATA_W'(st_ff.pcnt);
					default: nxt_st.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.cfg <= `SCID_CFG_RESET;
			st_ff.tlim <= `SCID_TLIM_RESET;
			st_ff.gain <= `SCID_GAIN_RESET;
			st_ff.enc <= SCID_ENC_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign pos_step = st_ff.step;
	assign pos_dir = st_ff.dir;
	assign speed_cmd_out = st_ff.spd;
	assign speed_cmd_reverse = st_ff.spd_rev;
	assign forward_allowed = st_ff.fwd_ok;
	assign reverse_allowed = st_ff.rev_ok;
	assign filter_set_two = st_ff.filt2;
	assign p_only_control = st_ff.ponly;
	assign gain_set_two = st_ff.gain2;
	assign torque_limit_active = st_ff.tl;
	assign torque_cmd_analog_a = st_ff.tcmd;
	assign speed_limit_analog = st_ff.spd_lim;
	assign enc_send_multiturn = st_ff.enc[`SCID_ENC_TURN_BIT];
	assign enc_send_incremental = st_ff.enc[`SCID_ENC_INCR_BIT];
endmodule

// *** tb/scid_decoder_checker.sv ***
/*
 Port checker for scid_decoder.
 Assumes bind to scid_decoder; ce drops only while no pin or request changes.
*/
`timescale 1ns/1ps
`include "scid_regs.svh"
module scid_decoder_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [`SCID_ADDR_W-1:0] reg_addr,
	input wire logic [`SCID_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`SCID_DATA_W-1:0] reg_rdata,
	input wire logic forward_travel_permit,
	input wire logic reverse_travel_permit,
	input wire logic encoder_data_request,
	input wire logic pos_step,
	input wire logic pos_dir,
	input wire logic forward_allowed,
	input wire logic reverse_allowed,
	input wire logic enc_send_multiturn,
	input wire logic enc_send_incremental
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	chk_fwd_block: assert property (!forward_travel_permit [*8] |-> !forward_allowed)
		else $error("forward_allowed with permit off");
	chk_rev_block: assert property (!reverse_travel_permit [*8] |-> !reverse_allowed)
		else $error("reverse_allowed with permit off");
	chk_step_legal: assert property (pos_step |-> (pos_dir ? forward_allowed : reverse_allowed))
		else $error("step into prohibited direction");
	chk_step_single: assert property (pos_step |=> !pos_step)
		else $error("pos_step longer than one cycle");
	chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("reg_rdata not zero outside read");
	chk_unmapped_rd: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_tlim_back: assert property (reg_wr && reg_addr == 4'h1 ##1 !reg_wr ##1 reg_rd && reg_addr == 4'h1
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("limit register readback");
	chk_enc_onehot: assert property (!(enc_send_multiturn && enc_send_incremental))
		else $error("encoder phases overlap");
	chk_enc_start: assert property ($rose(encoder_data_request) |-> ##[1:12] enc_send_multiturn)
		else $error("multiturn send late");
	chk_enc_abort: assert property (!encoder_data_request [*8] |-> !(enc_send_multiturn || enc_send_incremental))
		else $error("encoder send without request");
endmodule
bind scid_decoder scid_decoder_checker i_scid_decoder_checker (.*);

// *** tb/scid_host_model.sv ***
/*
 Host controller model: one command pulse per request, a full four-edge cycle in quadrature.
 Assumes the bench routes pin_a/pin_b to the selected port.
*/
`timescale 1ns/1ps
module scid_host_model (
	input wire logic clk_sys,
	input wire logic req,
	input wire logic fwd,
	input wire logic [1:0] fmt,
	input wire logic [7:0] half,
	output logic pin_a,
	output logic pin_b,
	output logic busy
);
	initial begin
		pin_a = 1'h0;
		pin_b = 1'h0;
		busy = 1'h0;
	end
	// Each level lasts half a period, so the rate never exceeds the port limit
	task automatic hold(input logic a, input logic b);
		pin_a <= a;
		pin_b <= b;
		repeat (half) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		if (req && !busy) begin
			busy <= 1'h1;
			case (fmt)
				2'h0: hold(!fwd, fwd);
				2'h1: begin
					hold(1'h0, fwd);
					hold(1'h1, fwd);
					hold(1'h0, fwd);
				end
				default: begin
					hold(fwd, !fwd);
					hold(1'h1, 1'h1);
					hold(!fwd, fwd);
				end
			endcase
			hold(1'h0, 1'h0);
			busy <= 1'h0;
		end
	end
endmodule

// *** tb/scid_decoder_bench.sv ***
/*
 Self-checking bench for scid_decoder.
 Assumes scid_host_model drives the selected pulse port.
*/
`timescale 1ns/1ps
module scid_decoder_bench;
	logic clk_sys = 1'h0, rstn = 1'h0, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, cfg_w = 32'h0;
	logic reverse_travel_permit = 1'h1, forward_travel_permit = 1'h1, zero_speed_clamp_in = 1'h1;
	logic speed_direction_switch_in = 1'h0, vibration_filter_switch_in = 1'h0, gain_switch_in = 1'h0;
	logic torque_limit_switch_in = 1'h0, encoder_data_request = 1'h0, torque_mode = 1'h0;
	logic [15:0] speed_cmd_in = 16'h1234, shared_analog_in = 16'h0ABC;
	logic [15:0] speed_cmd_out, torque_limit_active, torque_cmd_analog_a, speed_limit_analog;
	logic oc_pulse_a_in, oc_pulse_b_in, ld_pulse_a_in, ld_pulse_b_in, pos_step, pos_dir, speed_cmd_reverse;
	logic forward_allowed, reverse_allowed, filter_set_two, p_only_control, gain_set_two, enc_send_multiturn;
	logic enc_send_incremental, req = 1'h0, fwd = 1'h0, noise = 1'h0, h_a, h_b, busy, lastdir;
	logic [7:0] half = 8'h14;
	int fail_count = 0, n_compared = 0, nstep = 0;
	scid_decoder i_scid_decoder (.*);
	scid_host_model i_scid_host_model (.clk_sys, .req, .fwd, .fmt(cfg_w[2:1]), .half, .pin_a(h_a), .pin_b(h_b), .busy);
	// The unselected port toggles every cycle and must be ignored
	assign oc_pulse_a_in = cfg_w[0] ? noise : h_a;
	assign oc_pulse_b_in = cfg_w[0] ? !noise : h_b;
	assign ld_pulse_a_in = cfg_w[0] ? h_a : noise;
	assign ld_pulse_b_in = cfg_w[0] ? h_b : !noise;
	always #25 clk_sys = !clk_sys;
	always @(posedge clk_sys) begin
		noise <= !noise;
		if (pos_step === 1'h1) begin
			nstep++;
			lastdir = pos_dir;
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 chk(nm, exp, reg_rdata);
	endtask
	function automatic logic [31:0] mk(input int p, f, c, v, g, t, s);
		return 32'(p | f << 1 | c << 3 | v << 5 | g << 6 | t << 7 | s << 9);
	endfunction
	task automatic cfg(input logic [31:0] v);
		wr(4'h0, v);
		cfg_w <= v;
	endtask
	task automatic settle;
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic step(input logic d);
		@(posedge clk_sys);
		fwd <= d;
		req <= 1'h1;
		@(posedge clk_sys);
		req <= 1'h0;
		@(posedge clk_sys);
		repeat (400) if (busy === 1'h1) @(posedge clk_sys);
		chk("host done", 0, busy);
		settle;
	endtask
	task automatic t_regs;
		rd(4'h0, 32'h0, "cfg reset");
		rd(4'h1, 32'h0, "tlim reset");
		wr(4'h1, 32'hBBBB_AAAA);
		rd(4'h1, 32'hBBBB_AAAA, "tlim");
		wr(4'h9, 32'hFFFF_FFFF);
		rd(4'h9, 32'h0, "unmapped");
		@(posedge clk_sys);
		ce <= 1'h0;
		wr(4'h4, 32'h5555_5555);
		ce <= 1'h1;
		rd(4'h4, 32'h0, "gain frozen");
		wr(4'h4, 32'h1357_9BDF);
		rd(4'h4, 32'h1357_9BDF, "gain");
		$display("t_regs done");
	endtask
	task automatic t_pulse;
		int n;
		for (int p = 0; p < 2; p++) begin
			for (int f = 0; f < 3; f++) begin
				cfg(mk(p, f, 0, 0, 0, 0, 0));
				half <= p ? 8'h14 : 8'h32;
				for (int d = 0; d < 2; d++) begin
					n = nstep;
					step(d[0]);
					chk("steps", f == 2 ? 4 : 1, nstep - n);
					chk("dir", d, lastdir);
				end
			end
		end
		$display("t_pulse done");
	endtask
	task automatic t_permit;
		int n;
		cfg(mk(1, 0, 0, 0, 0, 0, 0));
		half <= 8'h14;
		for (int k = 0; k < 2; k++) begin
			forward_travel_permit <= k[0];
			reverse_travel_permit <= !k[0];
			settle;
			chk("fwd ok", k, forward_allowed);
			chk("rev ok", !k[0], reverse_allowed);
			chk("spd permit", k ? 16'h1234 : 16'h0, speed_cmd_out);
			n = nstep;
			step(!k[0]);
			chk("blocked", n, nstep);
			if (k == 0) rd(4'h2, 32'h0000_000D, "stat hit");
			step(k[0]);
			chk("passed", n + 1, nstep);
			if (k == 0) begin
				wr(4'h2, 32'h0000_0001);
				rd(4'h2, 32'h0000_0004, "stat clear");
				rd(4'h3, 32'hFFFF_FFFF, "pos count");
			end
		end
		forward_travel_permit <= 1'h1;
		reverse_travel_permit <= 1'h1;
		$display("t_permit done");
	endtask
	task automatic t_speed;
		cfg(mk(1, 0, 1, 0, 0, 0, 0));
		zero_speed_clamp_in <= 1'h0;
		settle;
		chk("clamped", 0, speed_cmd_out);
		cfg(mk(1, 0, 0, 0, 0, 0, 0));
		speed_direction_switch_in <= 1'h1;
		settle;
		chk("clamp off", 16'h1234, speed_cmd_out);
		chk("dir ignored", 0, speed_cmd_reverse);
		cfg(mk(1, 0, 2, 0, 0, 0, 0));
		settle;
		chk("dir rev", 1, speed_cmd_reverse);
		speed_direction_switch_in <= 1'h0;
		zero_speed_clamp_in <= 1'h1;
		settle;
		chk("dir fwd", 0, speed_cmd_reverse);
		$display("t_speed done");
	endtask
	task automatic t_switch;
		cfg(mk(1, 0, 0, 1, 0, 0, 0));
		vibration_filter_switch_in <= 1'h1;
		gain_switch_in <= 1'h1;
		settle;
		chk("filter two", 1, filter_set_two);
		chk("p only", 1, p_only_control);
		cfg(mk(1, 0, 0, 1, 1, 0, 0));
		settle;
		chk("gain two", 1, gain_set_two);
		cfg(mk(1, 0, 0, 0, 0, 3, 0));
		settle;
		chk("tlim one", 16'hAAAA, torque_limit_active);
		torque_limit_switch_in <= 1'h1;
		settle;
		chk("tlim two", 16'hBBBB, torque_limit_active);
		$display("t_switch done");
	endtask
	task automatic t_enc;
		@(posedge clk_sys);
		encoder_data_request <= 1'h1;
		repeat (40) if (enc_send_multiturn !== 1'h1) @(posedge clk_sys);
		chk("multiturn", 1, enc_send_multiturn);
		repeat (40) if (enc_send_incremental !== 1'h1) @(posedge clk_sys);
		chk("incremental", 1, enc_send_incremental);
		encoder_data_request <= 1'h0;
		cfg(mk(1, 0, 0, 0, 0, 0, 0));
		torque_mode <= 1'h1;
		settle;
		chk("enc idle", 0, enc_send_multiturn | enc_send_incremental);
		chk("torque cmd", 16'h0ABC, torque_cmd_analog_a);
		cfg(mk(1, 0, 0, 0, 0, 0, 1));
		settle;
		chk("speed limit", 16'h0ABC, speed_limit_analog);
		$display("t_enc done");
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'h1;
		t_regs;
		t_pulse;
		t_permit;
		t_speed;
		t_switch;
		t_enc;
		complete_run;
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		fail_count++;
		complete_run;
	end
endmodule
